// ===== rtl/wake_timer.sv
// Sleep wake-up timer with duty-cycled listening and serial register port
//
// Function
// - Wake timer ticks from internal 32.768 kHz RC oscillator by default.
// - With timer enabled during sleep, count the programmed period.
// - On expiry set the wake-timer interrupt request if enabled.
// - Live 16-bit count readable at offsets 17 (high) and 18 (low).
// - Period is 4 times mantissa times two to the exponent, in 32.768 kHz ticks.
// - Offset 14 holds exponent in bits 5:2, fine divider in 1:0, reset zero.
// - Mantissa high byte at 15, low byte at 16, both reset zero.
// - Enabled expiry drives the active-low interrupt output low.
// - Enabled expiry leaves sleep and starts the main crystal oscillator.
// - With interrupt disabled expiry pulses a pin and, in duty mode, starts listening; control and flag unchanged.
// - Crystal select repurposes general pin zero as crystal connection.
// - Crystal select moves wake timer and duty mode onto the crystal.
// - No preamble and sync during a wake: back to sleep until next period.
// - Preamble and sync found: extend receiver on-time by listening duration.
// - Same exponent scales wake period and listening duration.
// - Listening duration field is held at offset 19h.
// - Control register 07h: timer enable bit 5, crystal select bit 4.
// - Interrupt enable register 06h: wake interrupt enable bit 3.
module wake_timer
    import wake_timer_pkg::*;
#(
    parameter int LF_DIV_CYCLES = LF_TICK_CYCLES
)(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // Serial register port
    input  wire logic sel_n_i,
    input  wire logic sclk_i,
    input  wire logic sdi_i,
    output logic      sdo_o,
    output logic      sdo_oe_o,
    // Low-frequency crystal on general pin zero
    input  wire logic general_pin_zero_i,
    output logic      general_pin_zero_xtal_mode_o,
    // Receiver handshake
    input  wire logic preamble_valid_i,
    input  wire logic preamble_invalid_i,
    input  wire logic sync_found_i,
    // Status outputs
    output logic      interrupt_request_n_o,
    output logic      main_xtal_enable_o,
    output logic      rx_on_o,
    output logic      wake_expiry_pin_o
);
    // Pin synchronisers: 3 stages, value taken when stages 2 and 3 agree
    localparam int NPIN = 4;
    // Reset to the idle pin levels so that no false edge follows reset
    localparam logic [NPIN-1:0] PIN_IDLE = 4'h1;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_flt_ff;
    logic [NPIN-1:0] pin_prev_ff;
    assign pin_raw = {general_pin_zero_i, sdi_i, sclk_i, sel_n_i};

    for (genvar g = 0; g < NPIN; g++)
    begin : g_sync
        logic [2:0] stage_ff;
        always_ff @(posedge clk_sys_i)
        begin
            if (!rst_n_i)
            begin
                stage_ff       <= {3{PIN_IDLE[g]}};
                pin_flt_ff[g]  <= PIN_IDLE[g];
                pin_prev_ff[g] <= PIN_IDLE[g];
            end
            else
            begin
                stage_ff       <= {stage_ff[1:0], pin_raw[g]};
                pin_prev_ff[g] <= pin_flt_ff[g];
                if (stage_ff[1] == stage_ff[2])
                    pin_flt_ff[g] <= stage_ff[2];
            end
        end
    end

    logic sel_active, sclk_rise, sclk_fall, xtal_rise, sel_start;
    assign sel_active = !pin_flt_ff[0];
    assign sel_start  = pin_prev_ff[0] && !pin_flt_ff[0];
    assign sclk_rise  = !pin_prev_ff[1] && pin_flt_ff[1];
    assign sclk_fall  = pin_prev_ff[1] && !pin_flt_ff[1];
    assign xtal_rise  = !pin_prev_ff[3] && pin_flt_ff[3];

    // Registers and serial port state
    logic [7:0]  ctrl1_ff, nxt_ctrl1, ctrl2_ff, nxt_ctrl2, irq_en_ff, nxt_irq_en;
    logic [7:0]  exp_cfg_ff, nxt_exp_cfg, duty_on_ff, nxt_duty_on;
    logic [15:0] mant_ff, nxt_mant, shift_ff, nxt_shift;
    logic [4:0]  bit_cnt_ff, nxt_bit_cnt;
    logic [7:0]  rd_shift_ff, nxt_rd_shift;
    logic        sdo_ff, nxt_sdo, wake_flag_ff, nxt_wake_flag;
    reg_access_type acc;

    // Timer state
    logic [31:0] lf_div_ff, nxt_lf_div;
    logic [17:0] pre_ff, nxt_pre;
    logic [15:0] count_ff, nxt_count;
    logic [7:0]  duty_cnt_ff, nxt_duty_cnt;
    duty_state_type duty_ff, nxt_duty;
    logic        irq_n_ff, nxt_irq_n, expiry_pin_ff, nxt_expiry_pin;
    logic        sdo_oe_ff, xtal_mode_ff, xtal_en_ff, rx_on_ff;

    logic [3:0]  exponent;
    logic        sleeping, timer_run, lf_tick, unit_done, expire, xtal_sel;
    logic [17:0] unit_last;

    function automatic logic [7:0] read_reg(input logic [6:0] addr);
        unique case (addr)
            ADDR_IRQ_STATUS_1: read_reg = 8'h00;
            ADDR_IRQ_STATUS_2: read_reg = {4'h0, wake_flag_ff, 3'h0};
            ADDR_IRQ_ENABLE_2: read_reg = irq_en_ff;
            ADDR_OP_CONTROL_1: read_reg = ctrl1_ff;
            ADDR_OP_CONTROL_2: read_reg = ctrl2_ff;
            ADDR_PERIOD_EXP:   read_reg = exp_cfg_ff;
            ADDR_MANT_HIGH:    read_reg = mant_ff[15:8];
            ADDR_MANT_LOW:     read_reg = mant_ff[7:0];
            ADDR_COUNT_HIGH:   read_reg = count_ff[15:8];
            ADDR_COUNT_LOW:    read_reg = count_ff[7:0];
            ADDR_DUTY_ON:      read_reg = duty_on_ff;
            default:           read_reg = 8'h00;
        endcase
    endfunction : read_reg

    assign exponent  = exp_cfg_ff[EXP_MSB:EXP_LSB];
    assign xtal_sel  = ctrl1_ff[XTAL_SEL_BIT];
    assign sleeping  = ctrl1_ff[2:0] == 3'h0;
    assign timer_run = ctrl1_ff[WAKE_TIMER_EN_BIT] && (sleeping || duty_ff != DUTY_IDLE);
    // Tick source swaps from the RC divider to the crystal edges
    assign lf_tick   = xtal_sel ? xtal_rise : (lf_div_ff == 32'(LF_DIV_CYCLES - 1));
    // One unit is 4 << exponent ticks; shared by period and duration
    assign unit_last = 18'((18'h1 << (UNIT_TICKS_LOG + 32'(exponent))) - 18'h1);
    assign unit_done = lf_tick && pre_ff == unit_last;
    assign expire    = timer_run && unit_done && mant_ff != 16'h0
                       && count_ff == 16'(mant_ff - 16'h1);

    // Register file and serial port
    always_comb
    begin
        nxt_ctrl1     = ctrl1_ff;
        nxt_ctrl2     = ctrl2_ff;
        nxt_irq_en    = irq_en_ff;
        nxt_exp_cfg   = exp_cfg_ff;
        nxt_duty_on   = duty_on_ff;
        nxt_mant      = mant_ff;
        nxt_shift     = shift_ff;
        nxt_bit_cnt   = bit_cnt_ff;
        nxt_rd_shift  = rd_shift_ff;
        nxt_sdo       = sdo_ff;
        nxt_wake_flag = wake_flag_ff;
        acc           = reg_access_type'(shift_ff);
        if (sel_start)
            nxt_bit_cnt = 5'h0;
        else if (sel_active && sclk_rise && bit_cnt_ff < 5'(FRAME_BITS))
        begin
            nxt_shift   = {shift_ff[14:0], pin_flt_ff[2]};
            nxt_bit_cnt = 5'(bit_cnt_ff + 5'h1);
            acc         = reg_access_type'(nxt_shift);
            if (nxt_bit_cnt == 5'(ADDR_BITS) && !nxt_shift[7])
            begin
                nxt_rd_shift = read_reg(nxt_shift[6:0]);
                // Reading status releases the flag
                if (nxt_shift[6:0] == ADDR_IRQ_STATUS_2)
                    nxt_wake_flag = 1'b0;
            end
            if (nxt_bit_cnt == 5'(FRAME_BITS) && acc.write)
            begin
                unique case (acc.addr)
                    ADDR_IRQ_ENABLE_2: nxt_irq_en      = acc.data;
                    ADDR_OP_CONTROL_1: nxt_ctrl1       = acc.data;
                    ADDR_OP_CONTROL_2: nxt_ctrl2       = acc.data;
                    ADDR_PERIOD_EXP:   nxt_exp_cfg     = {2'h0, acc.data[5:0]};
                    ADDR_MANT_HIGH:    nxt_mant[15:8]  = acc.data;
                    ADDR_MANT_LOW:     nxt_mant[7:0]   = acc.data;
                    ADDR_DUTY_ON:      nxt_duty_on     = acc.data;
                    default:           nxt_mant        = mant_ff;
                endcase
            end
        end
        else if (sel_active && sclk_fall && bit_cnt_ff >= 5'(ADDR_BITS))
        begin
            nxt_sdo      = rd_shift_ff[7];
            nxt_rd_shift = {rd_shift_ff[6:0], 1'b0};
        end
        // Expiry sets after any clear so a coincident read never loses it
        if (expire && irq_en_ff[WAKE_IRQ_EN_BIT])
        begin
            nxt_wake_flag          = 1'b1;
            nxt_ctrl1[XTAL_ON_BIT] = 1'b1;
        end
    end

    // Timer, duty-cycle sequencer and outputs
    always_comb
    begin
        nxt_lf_div     = lf_tick || xtal_sel ? 32'h0 : 32'(lf_div_ff + 32'h1);
        nxt_pre        = pre_ff;
        nxt_count      = count_ff;
        nxt_duty       = duty_ff;
        nxt_duty_cnt   = duty_cnt_ff;
        nxt_expiry_pin = expire && !irq_en_ff[WAKE_IRQ_EN_BIT];
        nxt_irq_n      = !(nxt_wake_flag && irq_en_ff[WAKE_IRQ_EN_BIT]);
        if (!ctrl1_ff[WAKE_TIMER_EN_BIT])
        begin
            nxt_pre   = 18'h0;
            nxt_count = 16'h0;
        end
        else if (timer_run && lf_tick)
        begin
            nxt_pre = unit_done ? 18'h0 : 18'(pre_ff + 18'h1);
            if (expire)
                nxt_count = 16'h0;
            else if (unit_done)
                nxt_count = 16'(count_ff + 16'h1);
        end
        unique case (duty_ff)
            DUTY_IDLE:
                if (expire && ctrl2_ff[DUTY_MODE_BIT])
                begin
                    nxt_duty     = DUTY_LISTEN;
                    nxt_duty_cnt = 8'h0;
                end
            DUTY_LISTEN:
                if (preamble_valid_i && sync_found_i)
                begin
                    nxt_duty     = DUTY_EXTEND;
                    nxt_duty_cnt = 8'h0;
                end
                else if (preamble_invalid_i || (unit_done && duty_cnt_ff >= duty_on_ff))
                    nxt_duty = DUTY_IDLE;
                else if (unit_done)
                    nxt_duty_cnt = 8'(duty_cnt_ff + 8'h1);
            DUTY_EXTEND:
                if (unit_done && duty_cnt_ff >= duty_on_ff)
                    nxt_duty = DUTY_IDLE;
                else if (unit_done)
                    nxt_duty_cnt = 8'(duty_cnt_ff + 8'h1);
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            ctrl1_ff      <= OP_CONTROL_1_RST;
            ctrl2_ff      <= OP_CONTROL_2_RST;
            irq_en_ff     <= IRQ_ENABLE_2_RST;
            exp_cfg_ff    <= PERIOD_EXP_RST;
            duty_on_ff    <= DUTY_ON_RST;
            mant_ff       <= {MANT_RST, MANT_RST};
            shift_ff      <= 16'h0;
            bit_cnt_ff    <= 5'h0;
            rd_shift_ff   <= 8'h00;
            sdo_ff        <= 1'b0;
            wake_flag_ff  <= 1'b0;
            lf_div_ff     <= 32'h0;
            pre_ff        <= 18'h0;
            count_ff      <= 16'h0;
            duty_ff       <= DUTY_IDLE;
            duty_cnt_ff   <= 8'h0;
            irq_n_ff      <= 1'b1;
            expiry_pin_ff <= 1'b0;
            sdo_oe_ff     <= 1'b0;
            xtal_mode_ff  <= 1'b0;
            xtal_en_ff    <= 1'b0;
            rx_on_ff      <= 1'b0;
        end
        else
        begin
            ctrl1_ff      <= nxt_ctrl1;
            ctrl2_ff      <= nxt_ctrl2;
            irq_en_ff     <= nxt_irq_en;
            exp_cfg_ff    <= nxt_exp_cfg;
            duty_on_ff    <= nxt_duty_on;
            mant_ff       <= nxt_mant;
            shift_ff      <= nxt_shift;
            bit_cnt_ff    <= nxt_bit_cnt;
            rd_shift_ff   <= nxt_rd_shift;
            sdo_ff        <= nxt_sdo;
            wake_flag_ff  <= nxt_wake_flag;
            lf_div_ff     <= nxt_lf_div;
            pre_ff        <= nxt_pre;
            count_ff      <= nxt_count;
            duty_ff       <= nxt_duty;
            duty_cnt_ff   <= nxt_duty_cnt;
            irq_n_ff      <= nxt_irq_n;
            expiry_pin_ff <= nxt_expiry_pin;
            sdo_oe_ff     <= sel_active;
            xtal_mode_ff  <= nxt_ctrl1[XTAL_SEL_BIT];
            xtal_en_ff    <= nxt_ctrl1[XTAL_ON_BIT];
            rx_on_ff      <= nxt_duty != DUTY_IDLE || nxt_ctrl1[RX_ON_BIT];
        end
    end

    assign sdo_o                        = sdo_ff;
    assign sdo_oe_o                     = sdo_oe_ff;
    assign general_pin_zero_xtal_mode_o = xtal_mode_ff;
    assign interrupt_request_n_o        = irq_n_ff;
    assign main_xtal_enable_o           = xtal_en_ff;
    assign rx_on_o                      = rx_on_ff;
    assign wake_expiry_pin_o            = expiry_pin_ff;

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    irq_follows_flag_a: assert property (expire && irq_en_ff[WAKE_IRQ_EN_BIT] |=> !interrupt_request_n_o)
        else $error("interrupt line not low after enabled expiry");
    flag_set_a: assert property (expire && irq_en_ff[WAKE_IRQ_EN_BIT] |=> wake_flag_ff)
        else $error("status flag not set on expiry");
    xtal_wake_a: assert property (expire && irq_en_ff[WAKE_IRQ_EN_BIT] |=> main_xtal_enable_o)
        else $error("main crystal not started on wake");
    pin_only_a: assert property (expire && !irq_en_ff[WAKE_IRQ_EN_BIT] && !sclk_rise
        |=> wake_expiry_pin_o && $stable(ctrl1_ff) && !$rose(wake_flag_ff))
        else $error("disabled expiry changed state");
    expire_count_a: assert property (expire |-> mant_ff != 16'h0 ##1 count_ff == 16'h0 && pre_ff == 18'h0)
        else $error("no restart after expiry");
    stopped_count_a: assert property (!ctrl1_ff[WAKE_TIMER_EN_BIT] |=> count_ff == 16'h0)
        else $error("count runs with timer disabled");
    irq_release_a: assert property (irq_en_ff[WAKE_IRQ_EN_BIT] && !wake_flag_ff && !expire |=> interrupt_request_n_o)
        else $error("interrupt line stuck low");
    extend_on_sync_a: assert property (duty_ff == DUTY_LISTEN && preamble_valid_i && sync_found_i |=> duty_ff == DUTY_EXTEND ##1 rx_on_o)
        else $error("no extension on sync");
    listen_drop_a: assert property (duty_ff == DUTY_LISTEN && preamble_invalid_i && !(preamble_valid_i && sync_found_i) |=> duty_ff == DUTY_IDLE)
        else $error("listening kept after invalid preamble");
    pin_mode_a: assert property ($rose(ctrl1_ff[XTAL_SEL_BIT]) |-> general_pin_zero_xtal_mode_o)
        else $error("pin not moved to crystal mode");

    wake_irq_c: cover property (expire && irq_en_ff[WAKE_IRQ_EN_BIT]);
    wake_pin_c: cover property (expire && !irq_en_ff[WAKE_IRQ_EN_BIT]);
    extend_c:   cover property (duty_ff == DUTY_EXTEND ##1 duty_ff == DUTY_IDLE);
    xtal_run_c: cover property (xtal_sel && expire);
endmodule : wake_timer

// ===== rtl/wake_timer_pkg.sv
// Constants, register map and carrier types of the sleep wake-up timer
package wake_timer_pkg;
    // Clock and low-frequency time base
    localparam int CLK_SYS_HZ     = 250_000_000;
    localparam int LF_CLOCK_HZ    = 32_768;
    localparam int LF_TICK_CYCLES = CLK_SYS_HZ / LF_CLOCK_HZ;
    localparam int UNIT_TICKS_LOG = 2;
    // Register offsets
    localparam logic [6:0] ADDR_IRQ_STATUS_1   = 7'h03;
    localparam logic [6:0] ADDR_IRQ_STATUS_2   = 7'h04;
    localparam logic [6:0] ADDR_IRQ_ENABLE_2   = 7'h06;
    localparam logic [6:0] ADDR_OP_CONTROL_1   = 7'h07;
    localparam logic [6:0] ADDR_OP_CONTROL_2   = 7'h08;
    localparam logic [6:0] ADDR_PERIOD_EXP     = 7'h14;
    localparam logic [6:0] ADDR_MANT_HIGH      = 7'h15;
    localparam logic [6:0] ADDR_MANT_LOW       = 7'h16;
    localparam logic [6:0] ADDR_COUNT_HIGH     = 7'h17;
    localparam logic [6:0] ADDR_COUNT_LOW      = 7'h18;
    localparam logic [6:0] ADDR_DUTY_ON        = 7'h19;
    // Field positions
    localparam int WAKE_STATUS_BIT   = 3;
    localparam int WAKE_IRQ_EN_BIT   = 3;
    localparam int WAKE_TIMER_EN_BIT = 5;
    localparam int XTAL_SEL_BIT      = 4;
    localparam int RX_ON_BIT         = 2;
    localparam int PLL_ON_BIT        = 1;
    localparam int XTAL_ON_BIT       = 0;
    localparam int DUTY_MODE_BIT     = 2;
    localparam int EXP_MSB           = 5;
    localparam int EXP_LSB           = 2;
    // Reset values
    localparam logic [7:0] IRQ_ENABLE_2_RST = 8'h03;
    localparam logic [7:0] OP_CONTROL_1_RST = 8'h01;
    localparam logic [7:0] OP_CONTROL_2_RST = 8'h00;
    localparam logic [7:0] PERIOD_EXP_RST   = 8'h00;
    localparam logic [7:0] MANT_RST         = 8'h00;
    localparam logic [7:0] DUTY_ON_RST      = 8'h00;
    // Serial frame: direction bit, 7 address bits, 8 data bits
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS  = 8;

    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_access_type;

    typedef enum {DUTY_IDLE, DUTY_LISTEN, DUTY_EXTEND} duty_state_type;
endpackage : wake_timer_pkg

// ===== dv/host_mcu_model.sv
// Host controller model: serial register master of the wake timer
module host_mcu_model
    import wake_timer_pkg::*;
(
    // Clock
    input  wire logic       clk_sys_i,
    // Serial pins
    output logic            sel_n_o,
    output logic            sclk_o,
    output logic            sdi_o,
    input  wire logic       sdo_i,
    // Read results
    output logic            rd_valid_o,
    output logic [7:0]      rd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Each serial phase spans six clocks, above the four the pin filter needs
    localparam int PHASE = 6;

    initial
    begin
        sel_n_o    = 1'b1;
        sclk_o     = 1'b0;
        sdi_o      = 1'b0;
        rd_valid_o = 1'b0;
        rd_data_o  = 8'h00;
    end

    // One access per frame; read data is sampled just before each of the eight data-bit rises
    task automatic access(input reg_access_type acc);
        logic [FRAME_BITS-1:0] frame;
        logic [7:0]            rd;
        frame = acc;
        rd    = 8'h00;
        @(negedge clk_sys_i);
        sel_n_o = 1'b0;
        repeat (PHASE) @(negedge clk_sys_i);
        for (int i = FRAME_BITS - 1; i >= 0; i--)
        begin
            sdi_o = frame[i];
            repeat (PHASE) @(negedge clk_sys_i);
            if (i < ADDR_BITS)
                rd = {rd[6:0], sdo_i};
            sclk_o = 1'b1;
            repeat (PHASE) @(negedge clk_sys_i);
            sclk_o = 1'b0;
        end
        repeat (PHASE) @(negedge clk_sys_i);
        sel_n_o = 1'b1;
        // Released data line must not keep its last level
        sdi_o = ~sdi_o;
        repeat (PHASE) @(negedge clk_sys_i);
        rd_data_o  = rd;
        rd_valid_o = ~acc.write;
        @(negedge clk_sys_i);
        rd_valid_o = 1'b0;
    endtask : access
endmodule : host_mcu_model

// ===== dv/tb_sleep_wake_timer_duty_cycle.sv
// Self-checking bench for the wake timer with duty-cycled listening
module tb_sleep_wake_timer_duty_cycle
    import wake_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Short prescale: one low-frequency tick every four clocks
    localparam int DIV = 4;

    logic       clk_sys_i, rst_n_i, sel_n, sclk, sdi, sdo;
    logic       pin_zero, xtal_mode, pre_ok, pre_bad, sync_ok, xtal_run;
    logic       irq_n, xtal_en, rx_on, expiry_pin, rd_valid, sdo_oe;
    logic [7:0] rd_data, v;
    logic [7:0] exp_q[$];
    int         n_fail, check_count, cyc, seed;
    logic [6:0] rst_addr[10] = '{ADDR_IRQ_STATUS_1, ADDR_IRQ_ENABLE_2, ADDR_OP_CONTROL_1, ADDR_OP_CONTROL_2,
        ADDR_PERIOD_EXP, ADDR_MANT_HIGH, ADDR_MANT_LOW, ADDR_COUNT_HIGH, ADDR_DUTY_ON, 7'h7F};
    logic [7:0] rst_val[10]  = '{8'h00, 8'h03, 8'h01, OP_CONTROL_2_RST, 8'h00, 8'h00, 8'h00, 8'h00,
        DUTY_ON_RST, 8'h00};
    logic [6:0] rw_addr[4]   = '{ADDR_PERIOD_EXP, ADDR_MANT_HIGH, ADDR_MANT_LOW, ADDR_DUTY_ON};
    logic [7:0] rw_mask[4]   = '{8'h3F, 8'hFF, 8'hFF, 8'hFF};

    wake_timer #(.LF_DIV_CYCLES(DIV)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n), .sclk_i(sclk), .sdi_i(sdi),
        .sdo_o(sdo), .sdo_oe_o(sdo_oe), .general_pin_zero_i(pin_zero), .general_pin_zero_xtal_mode_o(xtal_mode),
        .preamble_valid_i(pre_ok), .preamble_invalid_i(pre_bad), .sync_found_i(sync_ok),
        .interrupt_request_n_o(irq_n), .main_xtal_enable_o(xtal_en), .rx_on_o(rx_on),
        .wake_expiry_pin_o(expiry_pin));

    host_mcu_model host (
        .clk_sys_i(clk_sys_i), .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // Crystal on pin zero, 40-clock period, frozen while not running
    always
    begin
        repeat (20) @(negedge clk_sys_i);
        if (xtal_run)
            pin_zero = ~pin_zero;
    end

    task automatic finish_test();
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [7:0] seen, input logic [7:0] expected, input string what);
        check_count++;
        if (seen !== expected)
        begin
            n_fail++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, expected);
        end
    endtask : check

    task automatic chk1(input logic seen, input logic expected, input string what);
        check({7'h00, seen}, {7'h00, expected}, what);
    endtask : chk1

    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        host.access('{write: 1'b1, addr: addr, data: data});
    endtask : wr

    task automatic rd(input logic [6:0] addr, input logic [7:0] expected);
        exp_q.push_back(expected);
        host.access('{write: 1'b0, addr: addr, data: 8'h00});
    endtask : rd

    // Bounded waits watch one of: 0 interrupt line, 1 expiry pin, 2 receiver on
    function automatic logic watched(input int which);
        return (which == 0) ? irq_n : (which == 1) ? expiry_pin : rx_on;
    endfunction : watched

    task automatic wait_for(input int which, input logic val, input int bound, output int n);
        n = 0;
        while (watched(which) !== val && n < bound)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        if (watched(which) !== val)
        begin
            n_fail++;
            $display("[FAIL] %0t wait ran out", $time);
            finish_test();
        end
    endtask : wait_for

    // Oldest noted expectation is matched against each completed read
    always @(posedge clk_sys_i)
    begin
        if (rd_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(8'h00, 8'hFF, "read with no expectation");
            else
                check(rd_data, exp_q.pop_front(), "register read");
        end
    end

    // A high serial clock always lies inside a frame, so the data line must be owned
    always @(negedge clk_sys_i)
    begin
        if (sclk === 1'b1)
            chk1(sdo_oe, 1'b1, "data line driven in frame");
    end

    initial
    begin
        {rst_n_i, pre_ok, pre_bad, sync_ok, pin_zero, xtal_run} = 6'h00;
        n_fail      = 0;
        check_count = 0;
        seed        = $urandom(32'h322B);
        repeat (12) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        chk1(irq_n, 1'b1, "interrupt idle");  // Line released
        chk1(sdo_oe, 1'b0, "data line idle");  // Released outside frames
        foreach (rst_addr[i])
            rd(rst_addr[i], rst_val[i]);  // Reset table
        foreach (rw_addr[i])
        begin
            v = 8'($urandom()) & rw_mask[i];
            wr(rw_addr[i], v);
            rd(rw_addr[i], v);  // Readback
        end
        wr(ADDR_COUNT_HIGH, 8'hFF);
        rd(ADDR_COUNT_HIGH, 8'h00);  // Count is read-only
        // Enabled expiry: exponent 1, mantissa 3, fine divider left at zero
        wr(ADDR_PERIOD_EXP, 8'h04);  // Coarse step suffices
        wr(ADDR_MANT_HIGH, 8'h00);
        wr(ADDR_MANT_LOW, 8'h03);
        wr(ADDR_IRQ_ENABLE_2, 8'h08);
        wr(ADDR_OP_CONTROL_1, 8'h20);
        chk1(xtal_en, 1'b0, "crystal off in sleep");  // Asleep
        wait_for(0, 1'b0, 400, cyc);
        chk1(cyc inside {[70:100]}, 1'b1, "enabled period");  // Period 96 clocks
        chk1(xtal_en, 1'b1, "crystal woken");  // Wake-up
        rd(ADDR_OP_CONTROL_1, 8'h21);  // Left sleep
        rd(ADDR_IRQ_STATUS_1, 8'h00);  // Host sweep
        chk1(irq_n, 1'b0, "interrupt held");  // Held until status read
        rd(ADDR_IRQ_STATUS_2, 8'h08);  // Source flag
        chk1(irq_n, 1'b1, "interrupt released");  // Cleared by read
        rd(ADDR_COUNT_LOW, 8'h00);  // Count restarted
        // Expiry with interrupt disabled: pin pulse only, every 32 clocks
        wr(ADDR_IRQ_ENABLE_2, 8'h00);
        wr(ADDR_PERIOD_EXP, 8'h00);
        wr(ADDR_MANT_LOW, 8'h02);
        wr(ADDR_OP_CONTROL_1, 8'h20);
        wait_for(1, 1'b1, 200, cyc);
        @(negedge clk_sys_i);
        wait_for(1, 1'b1, 200, cyc);
        chk1(cyc == 31, 1'b1, "pin pulse spacing");  // Two units of 16
        chk1(irq_n, 1'b1, "no interrupt");  // Gated off
        rd(ADDR_OP_CONTROL_1, 8'h20);  // State kept
        // Live count: mantissa 0102h, read high byte while near 256 units
        wr(ADDR_OP_CONTROL_1, 8'h00);
        wr(ADDR_MANT_HIGH, 8'h01);
        wr(ADDR_OP_CONTROL_1, 8'h20);
        repeat (3996) @(negedge clk_sys_i);
        rd(ADDR_COUNT_HIGH, 8'h01);  // Running count
        // Crystal time base: nothing moves until the crystal runs
        wr(ADDR_OP_CONTROL_1, 8'h00);
        wr(ADDR_MANT_HIGH, 8'h00);
        wr(ADDR_MANT_LOW, 8'h01);
        wr(ADDR_IRQ_ENABLE_2, 8'h08);
        wr(ADDR_OP_CONTROL_1, 8'h10);
        chk1(xtal_mode, 1'b1, "pin zero repurposed");  // Crystal pin
        wr(ADDR_OP_CONTROL_1, 8'h30);
        repeat (300) @(negedge clk_sys_i);
        chk1(irq_n, 1'b1, "no expiry without crystal");  // Off the oscillator
        xtal_run = 1'b1;
        wait_for(0, 1'b0, 400, cyc);
        xtal_run = 1'b0;
        rd(ADDR_IRQ_STATUS_2, 8'h08);  // Crystal expiry
        // Duty mode: period 8 units of 32 clocks, listening window 2 units
        wr(ADDR_IRQ_ENABLE_2, 8'h00);
        wr(ADDR_OP_CONTROL_1, 8'h00);
        wr(ADDR_PERIOD_EXP, 8'h04);
        wr(ADDR_MANT_LOW, 8'h08);
        wr(ADDR_DUTY_ON, 8'h01);  // Window well inside period
        wr(ADDR_OP_CONTROL_2, 8'h04);
        wr(ADDR_OP_CONTROL_1, 8'h20);
        wait_for(2, 1'b1, 400, cyc);
        repeat (4) @(negedge clk_sys_i);
        pre_bad = 1'b1;
        @(negedge clk_sys_i);
        pre_bad = 1'b0;
        wait_for(2, 1'b0, 8, cyc);  // Back to sleep
        wait_for(2, 1'b1, 400, cyc);
        chk1(cyc inside {[236:256]}, 1'b1, "next wake");  // Next period
        pre_ok  = 1'b1;
        sync_ok = 1'b1;
        wait_for(2, 1'b0, 200, cyc);
        chk1(cyc inside {[60:72]}, 1'b1, "extended on-time");  // Two units of 32
        {pre_ok, sync_ok} = 2'b00;
        wr(ADDR_OP_CONTROL_1, 8'h00);
        rd(ADDR_DUTY_ON, 8'h01);  // Duration field
        finish_test();
    end
endmodule : tb_sleep_wake_timer_duty_cycle
